// ===== rtl/rgbs_defines.vh
// Register offsets, field positions, reset values and codes for the sensor.
`ifndef RGBS_DEFINES_VH
`define RGBS_DEFINES_VH

`define RGBS_I2C_ADDR 7'h44
`define RGBS_RESET_CMD 8'h46

`define RGBS_OFF_ID_RESET 8'h00
`define RGBS_OFF_CONFIG_1 8'h01
`define RGBS_OFF_IR_COMP 8'h02
`define RGBS_OFF_STATUS 8'h08
`define RGBS_OFF_GREEN_LO 8'h09
`define RGBS_OFF_GREEN_HI 8'h0A
`define RGBS_OFF_RED_LO 8'h0B
`define RGBS_OFF_RED_HI 8'h0C
`define RGBS_OFF_BLUE_LO 8'h0D
`define RGBS_OFF_BLUE_HI 8'h0E

`define RGBS_CONFIG_1_RESET 5'h00
`define RGBS_IR_COMP_RESET 7'h00
`define RGBS_STATUS_RESET 8'h04
`define RGBS_RESULT_RESET 16'h0000

`define RGBS_CFG1_MODE_MSB 2
`define RGBS_CFG1_RANGE_BIT 3
`define RGBS_CFG1_RES_BIT 4
`define RGBS_IRC_SEL_BIT 7
`define RGBS_IRC_ADJ_MSB 5
`define RGBS_STAT_DONE_BIT 1
`define RGBS_STAT_SUPPLY_LOSS_CONDITION_BIT 2

`define RGBS_IR_OFFSET_CODES 8'h6A
`define RGBS_RES12_MASK 16'h0FFF

`define RGBS_MODE_POWER_DOWN 3'h0
`define RGBS_MODE_GREEN 3'h1
`define RGBS_MODE_RED 3'h2
`define RGBS_MODE_BLUE 3'h3
`define RGBS_MODE_STANDBY 3'h4
`define RGBS_MODE_GRB 3'h5
`define RGBS_MODE_GR 3'h6
`define RGBS_MODE_GB 3'h7

`define RGBS_CHAN_NONE 2'h0
`define RGBS_CHAN_GREEN 2'h1
`define RGBS_CHAN_RED 2'h2
`define RGBS_CHAN_BLUE 2'h3

`endif

// ===== rtl/rgbs_sensor.v
// Register file, I2C target and channel sequencer of the colour sensor.
`timescale 1ns/100ps
`default_nettype none
`include "rgbs_defines.vh"

module rgbs_sensor #(
  parameter [7:0] DEVICE_ID = 8'hA5
)
(
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire supply_loss_i,
  input wire conv_done_i,
  input wire [15:0] conv_data_i,
  output wire conv_start_o,
  output wire [1:0] conv_channel_o,
  output wire [2:0] mode_o,
  output wire range_o,
  output wire resolution_o,
  output wire [7:0] ir_compensation_o
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ADDR_ACK = 4'h2;
  localparam [3:0] ST_REG = 4'h3;
  localparam [3:0] ST_REG_ACK = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WDATA_ACK = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;

  reg scl_meta_reg, scl_sync_reg, scl_prev_reg;
  reg sda_meta_reg, sda_sync_reg, sda_prev_reg;
  reg supply_loss_condition_meta_reg, supply_loss_condition_sync_reg;
  reg [3:0] state_reg;
  reg [3:0] bitcnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [7:0] ptr_reg;
  reg rw_reg, oe_reg, mack_reg, snap_reg;
  reg wr_en_reg;
  reg [7:0] wr_ptr_reg, wr_data_reg;
  reg soft_rst_reg;
  reg [4:0] config1_reg;
  reg ir_sel_reg;
  reg [5:0] ir_adj_reg;
  reg [7:0] ir_comp_reg;
  reg done_flag_reg, supply_loss_condition_flag_reg;
  reg busy_reg, start_reg;
  reg [1:0] chan_reg, last_chan_reg;
  reg [15:0] result_reg [0:2];
  reg [15:0] shadow_reg [0:2];
  reg [7:0] rd_byte;
  reg [1:0] first_chan;

  wire rst_all = rst_i | soft_rst_reg;
  wire [7:0] status_default = `RGBS_STATUS_RESET;
  wire scl_rise = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_sync_reg & scl_prev_reg;
  wire i2c_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  wire i2c_stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  wire [2:0] mode = config1_reg[`RGBS_CFG1_MODE_MSB:0];
  wire active = (mode != `RGBS_MODE_POWER_DOWN) &&
                (mode != `RGBS_MODE_STANDBY);
  wire store = busy_reg & conv_done_i;
  wire [1:0] chan_view = busy_reg ? chan_reg : `RGBS_CHAN_NONE;
  wire [15:0] conv_masked = config1_reg[`RGBS_CFG1_RES_BIT] ?
                            (conv_data_i & `RGBS_RES12_MASK) : conv_data_i;

  // The first stage of each synchroniser feeds only the second.
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      supply_loss_condition_meta_reg <= 1'b0;
      supply_loss_condition_sync_reg <= 1'b0;
    end
    else
    begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      supply_loss_condition_meta_reg <= supply_loss_i;
      supply_loss_condition_sync_reg <= supply_loss_condition_meta_reg;
    end
  end

  // Result reads come from the shadow copy so both bytes of a value match.
  always @*
  begin
    case (ptr_reg)
      `RGBS_OFF_ID_RESET: rd_byte = DEVICE_ID;
      `RGBS_OFF_CONFIG_1: rd_byte = {3'h0, config1_reg};
      `RGBS_OFF_IR_COMP: rd_byte = {ir_sel_reg, 1'b0, ir_adj_reg};
      `RGBS_OFF_STATUS: rd_byte = {2'h0, chan_view, 1'b0, supply_loss_condition_flag_reg,
                                   done_flag_reg, 1'b0};
      `RGBS_OFF_GREEN_LO: rd_byte = shadow_reg[0][7:0];
      `RGBS_OFF_GREEN_HI: rd_byte = shadow_reg[0][15:8];
      `RGBS_OFF_RED_LO: rd_byte = shadow_reg[1][7:0];
      `RGBS_OFF_RED_HI: rd_byte = shadow_reg[1][15:8];
      `RGBS_OFF_BLUE_LO: rd_byte = shadow_reg[2][7:0];
      `RGBS_OFF_BLUE_HI: rd_byte = shadow_reg[2][15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  // Serial target; samples on SCL rise and changes SDA after SCL falls.
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
      snap_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_ptr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      snap_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      if (i2c_start)
      begin
        state_reg <= ST_ADDR;
        bitcnt_reg <= 4'h0;
        oe_reg <= 1'b0;
      end
      else if (i2c_stop)
      begin
        state_reg <= ST_IDLE;
        oe_reg <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state_reg)
          ST_ADDR, ST_REG, ST_WDATA:
          begin
            if (bitcnt_reg != 4'h8)
            begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
          end
          ST_RDATA: bitcnt_reg <= bitcnt_reg + 4'h1;
          ST_RACK: mack_reg <= ~sda_sync_reg;
          default: mack_reg <= mack_reg;
        endcase
      end
      else if (scl_fall)
      begin
        case (state_reg)
          ST_ADDR:
          begin
            if (bitcnt_reg == 4'h8)
            begin
              bitcnt_reg <= 4'h0;
              if (shift_reg[7:1] == `RGBS_I2C_ADDR)
              begin
                oe_reg <= 1'b1;
                rw_reg <= shift_reg[0];
                snap_reg <= shift_reg[0];
                state_reg <= ST_ADDR_ACK;
              end
              else
                state_reg <= ST_IDLE;
            end
          end
          ST_ADDR_ACK:
          begin
            bitcnt_reg <= 4'h0;
            if (rw_reg)
            begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RDATA;
            end
            else
            begin
              oe_reg <= 1'b0;
              state_reg <= ST_REG;
            end
          end
          ST_REG:
          begin
            if (bitcnt_reg == 4'h8)
            begin
              ptr_reg <= shift_reg;
              oe_reg <= 1'b1;
              state_reg <= ST_REG_ACK;
            end
          end
          ST_REG_ACK, ST_WDATA_ACK:
          begin
            oe_reg <= 1'b0;
            bitcnt_reg <= 4'h0;
            if (state_reg == ST_WDATA_ACK)
              ptr_reg <= ptr_reg + 8'h01;
            state_reg <= ST_WDATA;
          end
          ST_WDATA:
          begin
            if (bitcnt_reg == 4'h8)
            begin
              oe_reg <= 1'b1;
              wr_en_reg <= 1'b1;
              wr_ptr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              state_reg <= ST_WDATA_ACK;
            end
          end
          ST_RDATA:
          begin
            if (bitcnt_reg == 4'h8)
            begin
              oe_reg <= 1'b0;
              state_reg <= ST_RACK;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              oe_reg <= ~tx_reg[6];
            end
          end
          ST_RACK:
          begin
            bitcnt_reg <= 4'h0;
            if (mack_reg)
            begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RDATA;
            end
            else
              state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Configuration registers; a soft reset lands one cycle after the write.
  always @(posedge clock_i)
  begin
    if (rst_all)
    begin
      config1_reg <= `RGBS_CONFIG_1_RESET;
      {ir_sel_reg, ir_adj_reg} <= `RGBS_IR_COMP_RESET;
      soft_rst_reg <= 1'b0;
      ir_comp_reg <= 8'h00;
    end
    else
    begin
      soft_rst_reg <= wr_en_reg && wr_ptr_reg == `RGBS_OFF_ID_RESET &&
                      wr_data_reg == `RGBS_RESET_CMD;
      if (wr_en_reg && wr_ptr_reg == `RGBS_OFF_CONFIG_1)
        config1_reg <= wr_data_reg[4:0];
      if (wr_en_reg && wr_ptr_reg == `RGBS_OFF_IR_COMP)
      begin
        ir_sel_reg <= wr_data_reg[`RGBS_IRC_SEL_BIT];
        ir_adj_reg <= wr_data_reg[`RGBS_IRC_ADJ_MSB:0];
      end
      // The largest sum, 106 offset plus 63 adjust codes, is 169, so it fits eight bits.
      ir_comp_reg <= (ir_sel_reg ? `RGBS_IR_OFFSET_CODES : 8'h00) +
                     {2'h0, ir_adj_reg};
    end
  end

  // Status flags; a hardware set always beats a host clear.
  always @(posedge clock_i)
  begin
    if (rst_all)
    begin
      supply_loss_condition_flag_reg <= status_default[`RGBS_STAT_SUPPLY_LOSS_CONDITION_BIT];
      done_flag_reg <= 1'b0;
    end
    else
    begin
      if (supply_loss_condition_sync_reg)
        supply_loss_condition_flag_reg <= 1'b1;
      else if (wr_en_reg && wr_ptr_reg == `RGBS_OFF_STATUS)
        supply_loss_condition_flag_reg <= wr_data_reg[`RGBS_STAT_SUPPLY_LOSS_CONDITION_BIT];
      if (store)
        done_flag_reg <= 1'b1;
      else if (start_reg)
        done_flag_reg <= 1'b0;
    end
  end

  // Next channel in green, red, blue order for the selected mode.
  always @*
  begin
    case (mode)
      `RGBS_MODE_GREEN: first_chan = `RGBS_CHAN_GREEN;
      `RGBS_MODE_RED: first_chan = `RGBS_CHAN_RED;
      `RGBS_MODE_BLUE: first_chan = `RGBS_CHAN_BLUE;
      `RGBS_MODE_GRB: first_chan = (last_chan_reg == `RGBS_CHAN_GREEN) ?
        `RGBS_CHAN_RED : (last_chan_reg == `RGBS_CHAN_RED) ?
        `RGBS_CHAN_BLUE : `RGBS_CHAN_GREEN;
      `RGBS_MODE_GR: first_chan = (last_chan_reg == `RGBS_CHAN_GREEN) ?
        `RGBS_CHAN_RED : `RGBS_CHAN_GREEN;
      `RGBS_MODE_GB: first_chan = (last_chan_reg == `RGBS_CHAN_GREEN) ?
        `RGBS_CHAN_BLUE : `RGBS_CHAN_GREEN;
      default: first_chan = `RGBS_CHAN_NONE;
    endcase
  end

  // Continuous sequencer; leaving an active mode abandons the conversion.
  always @(posedge clock_i)
  begin
    if (rst_all)
    begin
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
      chan_reg <= `RGBS_CHAN_NONE;
      last_chan_reg <= `RGBS_CHAN_NONE;
    end
    else
    begin
      start_reg <= 1'b0;
      if (!active)
      begin
        busy_reg <= 1'b0;
        chan_reg <= `RGBS_CHAN_NONE;
        last_chan_reg <= `RGBS_CHAN_NONE;
      end
      else if (!busy_reg)
      begin
        busy_reg <= 1'b1;
        start_reg <= 1'b1;
        chan_reg <= first_chan;
      end
      else if (conv_done_i)
      begin
        busy_reg <= 1'b0;
        last_chan_reg <= chan_reg;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen_result
      always @(posedge clock_i)
      begin
        if (rst_all)
        begin
          result_reg[g] <= `RGBS_RESULT_RESET;
          shadow_reg[g] <= `RGBS_RESULT_RESET;
        end
        else
        begin
          if (store && chan_reg == g + 1)
            result_reg[g] <= conv_masked;
          if (snap_reg)
            shadow_reg[g] <= result_reg[g];
        end
      end
    end
  endgenerate

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign conv_start_o = start_reg;
  assign conv_channel_o = chan_reg;
  assign mode_o = mode;
  assign range_o = config1_reg[`RGBS_CFG1_RANGE_BIT];
  assign resolution_o = config1_reg[`RGBS_CFG1_RES_BIT];
  assign ir_compensation_o = ir_comp_reg;

endmodule
`default_nettype wire

// ===== dv/rgbs_host.sv
// I2C host model that drives the sensor's clock and data pins.
`timescale 1ns/100ps
`default_nettype none
module rgbs_host (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // Each phase is a quarter of the 125 ns bit period; the high and low
  // halves each stay well above the four clocks the synchronisers need.
  localparam realtime QTR = 31.25;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start();
    sda_low_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_low_o = 1'b1;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_low_o = 1'b0;
    #QTR;
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_low_o = !b;
    #QTR scl_o = 1'b1;
    #QTR r = sda_i;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(!more, r);
  endtask
endmodule
`default_nettype wire

// ===== dv/rgbs_chk.sv
// Checker for the sensor's converter sequencing and data pin timing.
`timescale 1ns/100ps
`default_nettype none
module rgbs_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic conv_done_i,
  input wire logic conv_start_o,
  input wire logic [1:0] conv_channel_o,
  input wire logic [2:0] mode_o,
  input wire logic [7:0] ir_compensation_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic idle = mode_o == 3'h0 || mode_o == 3'h4;
  wire logic [1:0] ch = conv_channel_o;
  property p_ir_span;
    ir_compensation_o <= 8'h3F ||
      (ir_compensation_o >= 8'h6A && ir_compensation_o <= 8'hA9);
  endproperty
  a_ir_span: assert property (p_ir_span)
    else $error("compensation outside both spans");
  // The sequencer drops busy on the edge that takes done, so the next
  // start pulse shows two edges after done.
  property p_restart;
    conv_done_i && !idle ##1 !idle |=> conv_start_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("no conversion start after done");
  property p_idle;
    idle && $past(idle) |-> !conv_start_o && ch == 2'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("activity in an idle mode");
  // The channel is chosen from the mode seen on the edge that starts it.
  property p_single;
    conv_start_o && $past(mode_o) inside {3'h1, 3'h2, 3'h3} |->
      ch == $past(mode_o[1:0]);
  endproperty
  a_single: assert property (p_single)
    else $error("wrong channel in single mode");
  property p_pair;
    conv_start_o && $past(mode_o[2:1]) == 2'h3 |->
      ch == 2'h1 || ch == {1'b1, $past(mode_o[0])};
  endproperty
  a_pair: assert property (p_pair)
    else $error("wrong channel in two channel mode");
  property p_order;
    conv_start_o && $past(mode_o) == 3'h5 && $past(mode_o, 2) == 3'h5 |->
      ch == ($past(ch) == 2'h3 ? 2'h1 : $past(ch) + 2'h1);
  endproperty
  a_order: assert property (p_order)
    else $error("channel order broken");
  property p_oe_low;
    !$stable(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_low: assert property (p_oe_low)
    else $error("data pin moved while clock high");
  property p_oe_hold;
    $rose(sda_oe_o) |-> sda_oe_o [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data pin drive too short");
endmodule
bind rgbs_sensor rgbs_chk chk (.clock_i(clock_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_oe_o(sda_oe_o), .conv_done_i(conv_done_i),
  .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
  .mode_o(mode_o), .ir_compensation_o(ir_compensation_o));
`default_nettype wire

// ===== dv/rgbs_sensor_tb.sv
// Self-checking bench for the sensor's registers over I2C.
`timescale 1ns/100ps
`default_nettype none
module rgbs_sensor_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_loss_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_data_i = 16'h0000;
  logic scl;
  logic host_low;
  wire logic sda_oe;
  wire logic sda = !(host_low || sda_oe);
  wire logic conv_start;
  wire logic [1:0] chan;
  wire logic [7:0] ir_comp;
  logic [15:0] cval [0:3] = '{16'h0000, 16'hA1B2, 16'hC3D4, 16'hE5F6};
  logic [15:0] ex [0:2][0:2] = '{'{16'hA1B2, 16'hC3D4, 16'hE5F6},
    '{16'h01B2, 16'h03D4, 16'hE5F6}, '{16'h01B2, 16'h03D4, 16'h05F6}};
  logic [7:0] cfg [0:2] = '{8'h05, 8'h16, 8'h17};
  logic [7:0] irw [0:3] = '{8'h00, 8'h3F, 8'h80, 8'hFF};
  logic [7:0] ire [0:3] = '{8'h00, 8'h3F, 8'h6A, 8'hA9};
  logic [7:0] rb [0:14];
  logic ack;
  int fail_count = 0;
  int tests_run = 0;
  int cdly = 0;
  int arm = 0;
  bit hold = 1'b0;
  bit oe_seen = 1'b0;
  bit fire;
  // The identity value is arbitrary.
  rgbs_sensor #(.DEVICE_ID(8'h5A)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .supply_loss_i(supply_loss_i), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .conv_start_o(conv_start),
    .conv_channel_o(chan), .mode_o(), .range_o(), .resolution_o(),
    .ir_compensation_o(ir_comp));
  rgbs_host host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
  initial
    forever #4 clock_i = ~clock_i;
  // Converter stand-in: answers twenty cycles after each start. Hold
  // pauses the count so the channel field stays put during a read; arm
  // counts acknowledges on the data pin and answers on the last one.
  always @(posedge clock_i)
  begin
    #1;
    fire = 1'b0;
    if (conv_start === 1'b1)
      cdly = 20;
    else if (cdly > 0 && !hold)
    begin
      cdly = cdly - 1;
      fire = (cdly == 0);
    end
    if (sda_oe === 1'b1 && !oe_seen && arm > 0)
    begin
      arm = arm - 1;
      if (arm == 0)
        fire = 1'b1;
    end
    oe_seen = (sda_oe === 1'b1);
    conv_done_i = fire;
    if (fire)
      conv_data_i = cval[chan];
  end
  task automatic results();
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    host.start();
    host.wbyte(8'h88, ack);
    chk(8'h01, {7'h00, ack});
    host.wbyte(a, ack);
    host.wbyte(d, ack);
    host.stop();
    repeat (4) @(posedge clock_i);
  endtask
  task automatic reg_rd(input logic [7:0] a, input int n);
    host.start();
    host.wbyte(8'h88, ack);
    host.wbyte(a, ack);
    host.start();
    host.wbyte(8'h89, ack);
    chk(8'h01, {7'h00, ack});
    for (int i = 0; i < n; i++)
      host.rbyte(i < n - 1, rb[i]);
    host.stop();
  endtask
  task automatic chk_def();
    reg_rd(8'h00, 15);
    for (int i = 0; i < 15; i++)
      chk(i == 0 ? 8'h5A : i == 8 ? 8'h04 : 8'h00, rb[i]);
  endtask
  task automatic wait_conv(input int n);
    int t = 0;
    while (n > 0 && t < 400)
    begin
      @(posedge clock_i);
      #2;
      if (conv_done_i === 1'b1)
        n--;
      t++;
    end
    if (n > 0)
    begin
      fail_count++;
      results();
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clock_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    chk_def();
    host.start();
    host.wbyte(8'h8A, ack);
    host.stop();
    chk(8'h00, {7'h00, ack});
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(8'h02, irw[i]);
      reg_rd(8'h02, 1);
      chk(irw[i] & 8'hBF, rb[0]);
      chk(ire[i], ir_comp);
    end
    reg_wr(8'h08, 8'hFB);
    reg_rd(8'h08, 1);
    chk(8'h00, rb[0]);
    @(posedge clock_i);
    #1 supply_loss_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #1 supply_loss_i = 1'b0;
    reg_rd(8'h08, 1);
    chk(8'h04, rb[0]);
    reg_wr(8'h08, 8'h00);
    for (int m = 1; m < 4; m++)
    begin
      reg_wr(8'h01, 8'(m));
      wait_conv(2);
      hold = 1'b1;
      reg_rd(8'h08, 1);
      hold = 1'b0;
      chk({2'h0, m[1:0], 4'h0}, rb[0]);
    end
    // An answer on the edge that acknowledges a standby write leaves the
    // done flag set with nothing converting after it.
    hold = 1'b1;
    arm = 3;
    reg_wr(8'h01, 8'h04);
    reg_rd(8'h08, 1);
    hold = 1'b0;
    chk(8'h02, rb[0]);
    for (int i = 0; i < 3; i++)
    begin
      // Standby first, so no conversion of the old mode lands afterwards.
      reg_wr(8'h01, 8'h04);
      reg_wr(8'h01, cfg[i]);
      wait_conv(4);
      reg_rd(8'h09, 6);
      for (int j = 0; j < 6; j++)
        chk(ex[i][j / 2] >> 8 * (j % 2), rb[j]);
    end
    reg_wr(8'h00, 8'h46);
    chk_def();
    chk(8'h00, ir_comp);
    results();
  end
endmodule
`default_nettype wire
